// *** hdl/dpm_map.svh ***
// register-free pin map and timing counts for the dual-port ram port controller
`ifndef DPM_MAP_SVH
`define DPM_MAP_SVH
`define DPM_ADDR_W        14
`define DPM_DATA_W        9
`define DPM_SEM_COUNT     8
`define DPM_SEM_SEL_W     3
`define DPM_MBOX_LEFT     14'h3ffe
`define DPM_MBOX_RIGHT    14'h3fff
`define DPM_SEM_REQUEST   1'h0
`define DPM_SEM_RELEASE   1'h1
`define DPM_ACCESS_NS     55
`define DPM_CLOCK_MHZ     10
`define DPM_ACCESS_CYC    (((`DPM_ACCESS_NS * `DPM_CLOCK_MHZ) + 999) / 1000)
`endif

// *** hdl/dpm_pkg.sv ***
// types shared by the dual-port ram port controller
package dpm_pkg;
    typedef enum logic [1:0] {
        DPM_OP_READ,
        DPM_OP_WRITE,
        DPM_OP_SEM_READ,
        DPM_OP_SEM_WRITE
    } dpm_op_e;

    typedef struct packed {
        dpm_op_e     op;
        logic [13:0] addr;
        logic [8:0]  data;
    } dpm_req_s;

    typedef struct packed {
        logic [8:0] data;
        logic       busyHit;
        logic       semOwned;
    } dpm_rsp_s;

    typedef struct packed {
        logic [13:0] addr;
        logic        portSelN;
        logic        semSelN;
        logic        writeN;
        logic        outDriveN;
        logic [8:0]  dataOut;
        logic        dataOe;
    } dpm_pins_s;
endpackage : dpm_pkg

// *** hdl/dpm_port_ctrl.sv ***
// one-port controller driving a dual-port ram with semaphores, busy and mailbox flag
`include "dpm_map.svh"
module dpm_port_ctrl
    import dpm_pkg::*;
(
    input  wire logic      clock,       // 10 mhz system clock
    input  wire logic      rst,         // async reset, active high
    input  wire logic      reqValid,    // user request present
    output logic           reqReady,    // ready to take a request this cycle
    input  wire dpm_req_s  req,         // user request
    output logic           rspValid,    // one-cycle answer pulse
    output dpm_rsp_s       rsp,         // answer data, registered
    output dpm_pins_s      pins,        // device pin drive, registered
    input  wire logic [8:0] dataIn,     // device data bus level
    input  wire logic      busyInN,     // device busy flag, active low
    input  wire logic      mboxIntN,    // device mailbox flag, active low
    output logic           mboxPending  // mailbox flag seen, registered
);
    // access phases; only one access is ever in flight
    typedef enum logic [1:0] {IDLE, SETUP, HOLD, DONE} dpm_state_e;

    // hold length in clocks, sized for the slowest speed grade
    localparam logic [3:0] ACCESS_CYC = 4'(`DPM_ACCESS_CYC);

    // sequencer state
    dpm_state_e state_q;        // current access phase
    dpm_state_e state_d;        // next access phase
    dpm_req_s   cur_q;          // request being served
    dpm_req_s   cur_d;          // next request being served
    logic [3:0] cnt_q;          // hold countdown
    logic [3:0] cnt_d;          // next hold countdown

    // pin drive state
    dpm_pins_s  pins_q;         // registered pin levels
    dpm_pins_s  pins_d;         // next pin levels

    // answer state
    dpm_rsp_s   rsp_q;          // registered answer
    dpm_rsp_s   rsp_d;          // next answer
    logic       rspValid_q;     // answer pulse
    logic       rspValid_d;     // next answer pulse

    // mailbox state
    logic       mbox_q;         // mailbox flag seen
    logic       mbox_d;         // next mailbox flag seen

    // decoded view of the access in flight
    logic       isSem;          // access goes to the latches
    logic       isWrite;        // access writes the device
    logic       takeReq;        // request accepted this clock
    logic       busyStall;      // far port holds the same word
    logic       lastHold;       // final clock of the hold

    // decode of the request in flight
    assign isSem     = (cur_q.op == DPM_OP_SEM_READ) || (cur_q.op == DPM_OP_SEM_WRITE);
    assign isWrite   = (cur_q.op == DPM_OP_WRITE) || (cur_q.op == DPM_OP_SEM_WRITE);

    // busy is only ever an input here, as on a slave or behind a master;
    // latches have no busy arbitration, so busy only stalls memory words
    assign busyStall = (state_q == HOLD) && !busyInN && !isSem;
    assign lastHold  = (state_q == HOLD) && !busyStall && (cnt_q <= 4'h1);
    assign takeReq   = (state_q == IDLE) && reqValid;

    // no queue: the user waits here, so this port never needs the other's timing
    assign reqReady  = (state_q == IDLE);

    // sequencer: next phase, request capture and hold count
    always_comb begin
        state_d = state_q;
        cur_d   = cur_q;
        cnt_d   = cnt_q;
        case (state_q)
            IDLE: begin
                if (reqValid) begin
                    cur_d   = req;
                    state_d = SETUP;
                end
            end
            SETUP: begin
                cnt_d   = ACCESS_CYC;
                state_d = HOLD;
            end
            HOLD: begin
                // a busy hold-off restarts the count, so the data gets a full access
                if (busyStall) begin
                    cnt_d = ACCESS_CYC;
                end else if (cnt_q > 4'h1) begin
                    cnt_d = cnt_q - 4'h1;
                end else begin
                    state_d = DONE;
                end
            end
            DONE: begin
                state_d = IDLE;
            end
            default: begin
                state_d = IDLE;
            end
        endcase
    end

    // sequencer registers
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state_q <= IDLE;
            cur_q   <= '0;
            cnt_q   <= 4'h0;
        end else begin
            state_q <= state_d;
            cur_q   <= cur_d;
            cnt_q   <= cnt_d;
        end
    end

    // pin drive; a memory address settles one clock before its select falls, a latch address only in its low bits
    always_comb begin
        pins_d = pins_q;
        case (state_q)
            IDLE: begin
                // both selects high lets the device idle this port in low power
                pins_d.portSelN  = 1'h1;
                pins_d.semSelN   = 1'h1;
                pins_d.writeN    = 1'h1;
                pins_d.outDriveN = 1'h1;
                pins_d.dataOe    = 1'h0;
                if (reqValid) begin
                    pins_d.addr = req.addr;
                end
            end
            SETUP: begin
                if (isSem) begin
                    pins_d.semSelN = 1'h0;
                    // only the low bits pick a latch; the rest stay at zero
                    pins_d.addr    = {11'h000, cur_q.addr[`DPM_SEM_SEL_W-1:0]};
                end else begin
                    pins_d.portSelN = 1'h0;
                end
                pins_d.writeN    = ~isWrite;
                pins_d.outDriveN = isWrite;
                pins_d.dataOe    = isWrite;
                // semaphore value sits on data bit zero only
                pins_d.dataOut   = isSem ? {8'h00, cur_q.data[0]} : cur_q.data;
            end
            HOLD: begin
                // pins stand still through the whole hold, busy stalls included
                pins_d = pins_q;
            end
            DONE: begin
                // every select and enable is released together, address and data out held; the device latches on select rise
                pins_d.portSelN  = 1'h1;
                pins_d.semSelN   = 1'h1;
                pins_d.writeN    = 1'h1;
                pins_d.outDriveN = 1'h1;
                pins_d.dataOe    = 1'h0;
            end
            default: begin
                pins_d = pins_q;
            end
        endcase
    end

    // pin registers; every pin leaves a flop, so no glitch reaches the device
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            pins_q <= '{addr:      14'h0000,
                        portSelN:  1'h1,
                        semSelN:   1'h1,
                        writeN:    1'h1,
                        outDriveN: 1'h1,
                        dataOut:   9'h000,
                        dataOe:    1'h0};
        end else begin
            pins_q <= pins_d;
        end
    end

    // answer: cleared on a take, filled on the last hold clock
    always_comb begin
        rsp_d      = rsp_q;
        rspValid_d = (state_q == DONE);
        if (takeReq) begin
            rsp_d = '0;
        end else if (busyStall) begin
            rsp_d.busyHit = 1'h1;
        end else if (lastHold) begin
            // the far port may read the same word now; the value is taken as it stands
            rsp_d.data     = isWrite ? 9'h000 : dataIn;
            // a latch reads low only to its owner
            rsp_d.semOwned = isSem && (dataIn[0] == `DPM_SEM_REQUEST);
        end
    end

    // answer registers
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rsp_q      <= '0;
            rspValid_q <= 1'h0;
        end else begin
            rsp_q      <= rsp_d;
            rspValid_q <= rspValid_d;
        end
    end

    // mailbox: the device keeps the flag, it is only retimed here;
    // clearing it is a plain read of the mailbox word by the user
    always_comb begin
        mbox_d = ~mboxIntN;
    end

    // mailbox register
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            mbox_q <= 1'h0;
        end else begin
            mbox_q <= mbox_d;
        end
    end

    // outputs straight from flops
    assign pins        = pins_q;
    assign rsp         = rsp_q;
    assign rspValid    = rspValid_q;
    assign mboxPending = mbox_q;
endmodule : dpm_port_ctrl

// *** verif/dpm_port_ctrl_chk.sv ***
// checker on the port controller ports
module dpm_port_ctrl_chk
    import dpm_pkg::*;
(
    input wire logic      clock,    // clk
    input wire logic      rst,      // reset
    input wire logic      reqValid, // offer
    input wire logic      reqReady, // idle
    input wire dpm_req_s  req,      // request
    input wire dpm_pins_s pins      // pins
);
    timeunit 1ns / 1ns;
    wire tk = reqValid && reqReady; // taken
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    // pins are set up two edges after a take
    property p_rd; tk && req.op == DPM_OP_READ |-> ##2 !pins.portSelN && pins.writeN; endproperty
    a_rd: assert property (p_rd) else $error("read pins");
    property p_sm; tk && req.op[1] |-> ##2 !pins.semSelN && pins.addr < 14'h0008; endproperty
    a_sm: assert property (p_sm) else $error("sem pins");
    property p_wd; tk && req.op[0] |-> ##2 pins.dataOut[0] == $past(req.data[0], 2); endproperty
    a_wd: assert property (p_wd) else $error("data bit");
    // between accesses both selects stay high so the port can idle
    property p_idle;
        reqReady |-> pins.portSelN && pins.semSelN && pins.writeN && pins.outDriveN && !pins.dataOe;
    endproperty
    a_idle: assert property (p_idle) else $error("pins not idle");
    // a latch access never selects the memory as well
    property p_excl; !pins.semSelN |-> pins.portSelN; endproperty
    a_excl: assert property (p_excl) else $error("both selects low");
    cover property (tk && req.op[1]);
    cover property (tk && req.op[0]);
    cover property (tk && !req.op[0]);
endmodule : dpm_port_ctrl_chk
bind dpm_port_ctrl dpm_port_ctrl_chk u_chk (.clock, .rst, .reqValid, .reqReady, .req, .pins);

// *** verif/dpm_ram_model.sv ***
// one-port view of the dual-port ram
module dpm_ram_model
    import dpm_pkg::*;
(
    input wire logic      clock,   // clk
    input wire dpm_pins_s pins,    // our pins
    input wire logic      farBusy, // far port on word
    input wire logic      farMbox, // far port hits 3ffe
    output logic [8:0]    dataIn,  // bus level
    output logic          busyInN, // busy
    output logic          mboxIntN // mailbox flag
);
    timeunit 1ns / 1ns;
    logic [8:0] mem [16384], last = 9'h000;
    logic [7:0] own = 8'h00;
    logic       flag = 1'b0;
    // busy arrives as from a master's busy output feeding this port
    assign busyInN = !(farBusy && !pins.portSelN);
    assign mboxIntN = !flag;
    // released bus toggles, so a stale value never passes
    assign dataIn = pins.dataOe ? pins.dataOut : pins.outDriveN ? ~last :
        !pins.portSelN ? mem[pins.addr] : {8'h00, !own[pins.addr[2:0]]};
    // far port holds latch six for good
    always @(posedge clock) begin
        last <= dataIn;
        if (!pins.portSelN && !pins.writeN) mem[pins.addr] <= pins.dataOut;
        if (!pins.semSelN && !pins.writeN)
            own[pins.addr[2:0]] <= !pins.dataOut[0] && pins.addr[2:0] != 3'h6;
        if (farMbox || (pins.writeN && !pins.portSelN && pins.addr == 14'h3ffe))
            flag <= farMbox;
    end
endmodule : dpm_ram_model

// *** verif/dpm_port_ctrl_tb.sv ***
// bench for the port controller
module dpm_port_ctrl_tb
    import dpm_pkg::*;
;
    timeunit 1ns / 1ns;
    logic clock = 0, rst = 1, reqValid = 0, farBusy = 0, farMbox = 0;
    logic reqReady, rspValid, busyInN, mboxIntN, mboxPending;
    logic [8:0] dataIn;
    dpm_req_s req = '0;
    dpm_rsp_s rsp;
    dpm_pins_s pins;
    wire [6:0] ctlView = {reqReady, rspValid, pins.portSelN, pins.semSelN, pins.writeN,
        pins.outDriveN, pins.dataOe};
    int n_errors = 0, checks_done = 0, cyc = 0;
    // op, address, data; a read row carries its answer
    dpm_req_s rows [10] = '{25'h0ffffa5, 25'h080005a, 25'h07fffa5, 25'h000005a, 25'h1fffbfe,
        25'h1000a01, 25'h1800c00, 25'h1000c00, 25'h1800bff, 25'h1000a00};
    dpm_port_ctrl u_dut (.clock, .rst, .reqValid, .reqReady, .req, .rspValid, .rsp, .pins,
        .dataIn, .busyInN, .mboxIntN, .mboxPending);
    dpm_ram_model u_ram (.clock, .pins, .farBusy, .farMbox, .dataIn, .busyInN, .mboxIntN);
    // clock and a ceiling against hangs
    initial forever #50 clock = ~clock;
    always @(posedge clock) if (++cyc == 3000) begin n_errors++; stop_test(); end
    task automatic chk(input logic [8:0] got, input logic [8:0] exp);
        checks_done++;
        if (got !== exp) begin n_errors++; $display("BAD %0t %h %h", $time, got, exp); end
    endtask : chk
    task automatic xfer(input dpm_req_s r);
        @(negedge clock) req = r;
        reqValid = 1;
        @(negedge clock) reqValid = 0;
        for (int i = 0; i < 40 && !rspValid; i++) @(negedge clock);
    endtask : xfer
    task automatic stop_test();
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : stop_test
    // table, then busy stall, mailbox and mid-access reset
    initial begin
        repeat (12) @(negedge clock);
        rst = 0;
        foreach (rows[i]) begin
            xfer(rows[i]);
            if (!rows[i].op[0])
                chk(rows[i].op[1] ? {8'h00, rsp.semOwned} : rsp.data, rows[i].data);
        end
        $display("table done");
        farBusy = 1;
        fork xfer(25'h000005a); #600 farBusy = 0; join
        chk({rsp.busyHit, rsp.data[7:0]}, 9'h15a);
        $display("busy done");
        farMbox = 1;
        @(negedge clock) farMbox = 0;
        @(negedge clock) chk({8'h00, mboxPending}, 9'h001);
        xfer(25'h07ffc00);
        @(negedge clock) chk({8'h00, mboxPending}, 9'h000);
        $display("mailbox done");
        // reset in mid-access drops every select at once, then a read recovers
        @(negedge clock) req = 25'h000005a;
        reqValid = 1;
        @(negedge clock) reqValid = 0;
        @(negedge clock) rst = 1;
        @(negedge clock) chk({2'h0, ctlView}, 9'h05e);
        rst = 0;
        xfer(25'h000005a);
        chk(rsp.data, 9'h05a);
        $display("reset done");
        stop_test();
    end
endmodule : dpm_port_ctrl_tb
